//--- core/plcsc_pkg.sv
/*
 Shared constants and carrier types for the link capability and link
 status/control register pair of one switch port.
 Assumes a single 10 MHz clock and a simple register access port.
*/
package plcsc_pkg;

   localparam logic [11:0] PLCSC_OFS_LINK_CAP    = 12'h074;
   localparam logic [11:0] PLCSC_OFS_LINK_STSCTL = 12'h078;

   // Capability and status field codes.
   localparam logic [3:0] PLCSC_SPEEDS_BOTH   = 4'h2;
   localparam logic [5:0] PLCSC_WIDTH_X1      = 6'h01;
   localparam logic [5:0] PLCSC_WIDTH_X2      = 6'h02;
   localparam logic [1:0] PLCSC_ASPM_SUP_BOTH = 2'h3;
   localparam logic [2:0] PLCSC_L0S_LAT_5G    = 3'h4;
   localparam logic [2:0] PLCSC_L0S_LAT_2G5   = 3'h5;
   localparam logic [2:0] PLCSC_L1_LAT_5G     = 3'h1;
   localparam logic [2:0] PLCSC_L1_LAT_2G5    = 3'h2;
   localparam logic [3:0] PLCSC_SPEED_2G5     = 4'h1;
   localparam logic [3:0] PLCSC_SPEED_5G      = 4'h2;

   // Field positions.
   localparam int PLCSC_BIT_SURPRISE   = 19;
   localparam int PLCSC_BIT_DLL_CAP    = 20;
   localparam int PLCSC_BIT_BWN_CAP    = 21;
   localparam int PLCSC_BIT_LINK_DIS   = 4;
   localparam int PLCSC_BIT_RETRAIN    = 5;
   localparam int PLCSC_BIT_COMMON_CLK = 6;
   localparam int PLCSC_BIT_EXT_SYNC   = 7;
   localparam int PLCSC_BIT_BWM_IE     = 10;
   localparam int PLCSC_BIT_ABW_IE     = 11;
   localparam int PLCSC_BIT_TRAINING   = 27;
   localparam int PLCSC_BIT_DLL_ACTIVE = 29;
   localparam int PLCSC_BIT_BWM_STS    = 30;
   localparam int PLCSC_BIT_ABW_STS    = 31;

   // Reset values of writable controls.
   localparam logic [1:0] PLCSC_ASPM_CTL_RST = 2'h0;
   localparam logic       PLCSC_SURPRISE_RST = 1'b1;

   // Ordered-set counts used with and without extended sync.
   localparam int unsigned PLCSC_EXT_FTS_COUNT = 4096;
   localparam int unsigned PLCSC_EXT_TS1_COUNT = 1024;
   localparam int unsigned PLCSC_STD_TS1_COUNT = 16;

   // Status inputs reported by the link training machine and data link layer.
   typedef struct packed {
      logic       link_up;
      logic       speed_5g;
      logic [5:0] width;
      logic       training;
      logic       dll_active;
      logic       fc_init_done;
      logic       retrain_done;
      logic       reliab_change;
      logic       auto_change;
      logic       went_down;
   } plcsc_link_sts_t;

   // Controls driven toward the link training machine.
   typedef struct packed {
      logic       link_disable;
      logic       retrain_pulse;
      logic       l0s_enable;
      logic       l1_enable;
      logic       rx_l0s_allow;
      logic       common_clk;
      logic       ext_sync;
      logic       surprise_en;
      logic       bwm_irq_req;
      logic       abw_irq_req;
   } plcsc_link_ctl_t;

endpackage

//--- core/plcsc_rw1c_flag.sv
/*
 One write-one-to-clear event flag with an interrupt request output.
 Assumes the owner gates set events to ports where the flag exists.
*/
`timescale 1ns/1ps
module plcsc_rw1c_flag
(
   // Clock and reset
   input  wire logic sys_clk_i,
   input  wire logic rst_b_i,
   // Event and software clear
   input  wire logic set_i,
   input  wire logic clr_i,
   input  wire logic irq_en_i,
   // Flag and request
   output logic      flag_o,
   output logic      irq_o
);
   logic next_flag;

   // A set in the same cycle as the clear wins, so no event is lost.
   assign next_flag = set_i | (flag_o & ~clr_i);
   assign irq_o     = flag_o & irq_en_i;

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         flag_o <= 1'b0;
      else
         flag_o <= next_flag;
   end
endmodule

//--- core/plcsc_regs.sv
/*
 Link capability and link status/control registers for one switch port.
 Assumes a synchronous register port with one-cycle write and read
 strobes, and status inputs from the link training machine.
*/
// Summary of operation
// - Supported-speeds field reads the code for 2.5 and 5.0 GT/s.
// - Maximum width is x1, or x2 on the upstream port when strapped so.
// - ASPM support field reads L0s and L1 supported.
// - L0s exit latency code follows current link speed.
// - L1 exit latency code follows current link speed.
// - Downstream surprise-down capability defaults one; clearing drops the surprise_en control toward the training machine.
// - Data-link-active reporting capability reads one downstream, zero upstream.
// - Bandwidth-notification capability reads one downstream, zero upstream.
// - Port number follows the port index; lane layout follows the configuration strap.
// - ASPM control selects none, L0s, L1 or both; resets to zero.
// - Receiver may always enter L0s regardless of ASPM control.
// - Link disable drives downstream link to Disabled; upstream reads zero.
// - Retrain reads zero; writing one downstream starts retraining.
// - Common-clock bit is software writable and resets to zero.
// - Extended sync selects 4096 FTS and 1024 TS1 ordered sets.
// - Two downstream enables gate bandwidth flag interrupts; both reset off.
// - Current speed reads one or two; defaults to the 2.5 GT/s code.
// - Negotiated width reads x1 when down; x2 only upstream.
// - Training bit shows requested downstream training in progress.
// - Data-link-active needs active layer, link up and flow control done.
// - Bandwidth-management flag sets on retrain done or reliability change.
// - Autonomous-bandwidth flag sets on non-reliability change without link down.
`timescale 1ns/1ps
module plcsc_regs
(
   // Clock and reset
   input  wire logic                       sys_clk_i,
   input  wire logic                       rst_b_i,
   // Port identity and strap
   input  wire logic [1:0]                 port_index_i,
   input  wire logic                       port_layout_strap_input_i,
   input  wire logic                       strap_override_valid_i,
   input  wire logic                       strap_override_i,
   input  wire logic                       surprise_override_we_i,
   input  wire logic                       surprise_override_i,
   // Register access
   input  wire logic                       reg_wr_i,
   input  wire logic                       reg_rd_i,
   input  wire logic [11:0]                reg_addr_i,
   input  wire logic [31:0]                reg_wdata_i,
   output logic [31:0]                     reg_rdata_o,
   output logic                            reg_rvalid_o,
   // Link side
   input  wire plcsc_pkg::plcsc_link_sts_t link_sts_i,
   output plcsc_pkg::plcsc_link_ctl_t      link_ctl_o,
   output logic [12:0]                     fts_count_o,
   output logic [10:0]                     ts1_count_o,
   output logic                            port_present_o
);
   import plcsc_pkg::*;

   logic        layout_sel;
   logic        strap_captured;
   logic [1:0]  aspm_ctl;
   logic        link_dis;
   logic        common_clk;
   logic        ext_sync;
   logic        bwm_ie;
   logic        abw_ie;
   logic        surprise_en;
   logic        retrain_pend;
   logic        bwm_flag;
   logic        abw_flag;
   logic        bwm_irq;
   logic        abw_irq;
   logic [1:0]  flag_set;
   logic [1:0]  flag_clr;
   logic [1:0]  flag_ie;
   logic [1:0]  flag_q;
   logic [1:0]  flag_irq;
   logic [31:0] next_rdata;

   // Decoding.
   wire         is_upstream = (port_index_i == 2'h0);
   wire         is_down     = ~is_upstream;
   wire         wr_cap      = reg_wr_i & (reg_addr_i == PLCSC_OFS_LINK_CAP);
   wire         wr_ctl      = reg_wr_i & (reg_addr_i == PLCSC_OFS_LINK_STSCTL);
   wire         rd_cap      = reg_addr_i == PLCSC_OFS_LINK_CAP;
   wire         rd_ctl      = reg_addr_i == PLCSC_OFS_LINK_STSCTL;

   // Layout one removes port 1 and widens port 0.
   wire         present     = ~(layout_sel & (port_index_i == 2'h1));
   wire [7:0]   port_num    = {6'h00, port_index_i};
   wire [5:0]   max_width   = (is_upstream & layout_sel) ? PLCSC_WIDTH_X2
                                                         : PLCSC_WIDTH_X1;

   // Speed reads the default code while the link is down rather than garbage.
   wire         fast_link   = link_sts_i.link_up & link_sts_i.speed_5g;
   wire [3:0]   cur_speed   = fast_link ? PLCSC_SPEED_5G : PLCSC_SPEED_2G5;

   // Latencies track speed; the FTS count follows extended sync, not speed.
   wire [2:0]   l0s_lat     = fast_link ? PLCSC_L0S_LAT_5G
                                        : PLCSC_L0S_LAT_2G5;
   wire [2:0]   l1_lat      = fast_link ? PLCSC_L1_LAT_5G
                                        : PLCSC_L1_LAT_2G5;
   wire         neg_x2      = is_upstream & link_sts_i.dll_active
                              & (link_sts_i.width == PLCSC_WIDTH_X2)
                              & (max_width == PLCSC_WIDTH_X2);
   wire [5:0]   neg_width   = neg_x2 ? PLCSC_WIDTH_X2 : PLCSC_WIDTH_X1;

   // Training shows a software request at once, before the machine picks it up.
   wire         training    = is_down & (retrain_pend | link_sts_i.training);
   // All three conditions are checked, so a stale layer flag cannot report a dead link.
   wire         dll_act     = is_down & link_sts_i.dll_active & link_sts_i.link_up
                              & link_sts_i.fc_init_done;

   // Flag events count only when the port did not pass through link down.
   wire         no_down     = is_down & ~link_sts_i.went_down;
   wire         bwm_set     = no_down & ((retrain_pend & link_sts_i.retrain_done)
                                         | link_sts_i.reliab_change);
   wire         abw_set     = no_down & link_sts_i.auto_change;
   wire         bwm_clr     = wr_ctl & reg_wdata_i[PLCSC_BIT_BWM_STS];
   wire         abw_clr     = wr_ctl & reg_wdata_i[PLCSC_BIT_ABW_STS];
   wire         retrain_req = wr_ctl & is_down & reg_wdata_i[PLCSC_BIT_RETRAIN];

   wire [31:0]  cap_word;
   wire [31:0]  ctl_word;

   // Capability word, most significant field first.
   assign cap_word = {port_num,
                      2'h0,
                      is_down,
                      is_down,
                      is_down & surprise_en,
                      1'b0,
                      l1_lat,
                      l0s_lat,
                      PLCSC_ASPM_SUP_BOTH,
                      max_width,
                      PLCSC_SPEEDS_BOTH};

   // Status half in the upper sixteen bits, control half in the lower.
   assign ctl_word = {abw_flag,
                      bwm_flag,
                      dll_act,
                      1'b0,
                      training,
                      1'b0,
                      neg_width,
                      cur_speed,
                      4'h0,
                      abw_ie,
                      bwm_ie,
                      2'h0,
                      ext_sync,
                      common_clk,
                      1'b0,
                      link_dis,
                      2'h0,
                      aspm_ctl};

   // A read in the same cycle as a write returns the value before the write.
   assign next_rdata = rd_cap ? cap_word : (rd_ctl ? ctl_word : 32'h0000_0000);

   // The strap is sampled once after reset release, never under reset.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
      begin
         strap_captured <= 1'b0;
         layout_sel     <= 1'b0;
      end
      else if (strap_override_valid_i)
      begin
         strap_captured <= 1'b1;
         layout_sel     <= strap_override_i;
      end
      else if (!strap_captured)
      begin
         strap_captured <= 1'b1;
         layout_sel     <= port_layout_strap_input_i;
      end
   end

   // Surprise-down capability is read-only to software; a side channel may clear it.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         surprise_en <= PLCSC_SURPRISE_RST;
      else if (surprise_override_we_i)
         surprise_en <= surprise_override_i;
   end

   // One short register per control field; upstream forces its downstream-only
   // controls to zero at the write, so they also read back as zero.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         aspm_ctl <= PLCSC_ASPM_CTL_RST;
      else if (wr_ctl)
         aspm_ctl <= reg_wdata_i[1:0];
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         link_dis <= 1'b0;
      else if (wr_ctl)
         link_dis <= is_down & reg_wdata_i[PLCSC_BIT_LINK_DIS];
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         common_clk <= 1'b0;
      else if (wr_ctl)
         common_clk <= reg_wdata_i[PLCSC_BIT_COMMON_CLK];
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         ext_sync <= 1'b0;
      else if (wr_ctl)
         ext_sync <= reg_wdata_i[PLCSC_BIT_EXT_SYNC];
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         bwm_ie <= 1'b0;
      else if (wr_ctl)
         bwm_ie <= is_down & reg_wdata_i[PLCSC_BIT_BWM_IE];
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         abw_ie <= 1'b0;
      else if (wr_ctl)
         abw_ie <= is_down & reg_wdata_i[PLCSC_BIT_ABW_IE];
   end

   // The pending retrain lasts until the training machine reports it done or the link goes down.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         retrain_pend <= 1'b0;
      else if (retrain_req)
         retrain_pend <= 1'b1;
      else if (link_sts_i.retrain_done | link_sts_i.went_down)
         retrain_pend <= 1'b0;
   end

   // Read data holds until the next read, so a slow master may pick it up late.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         reg_rdata_o <= 32'h0000_0000;
      else if (reg_rd_i)
         reg_rdata_o <= next_rdata;
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         reg_rvalid_o <= 1'b0;
      else
         reg_rvalid_o <= reg_rd_i;
   end

   // Entry 0 is the bandwidth-management flag and entry 1 the autonomous one.
   assign flag_set = {abw_set, bwm_set};
   assign flag_clr = {abw_clr, bwm_clr};
   assign flag_ie  = {abw_ie, bwm_ie};

   for (genvar g = 0; g < 2; g++)
   begin : g_flag
      plcsc_rw1c_flag u_flag
      (
         .sys_clk_i (sys_clk_i),
         .rst_b_i   (rst_b_i),
         .set_i     (flag_set[g]),
         .clr_i     (flag_clr[g]),
         .irq_en_i  (flag_ie[g]),
         .flag_o    (flag_q[g]),
         .irq_o     (flag_irq[g])
      );
   end

   assign bwm_flag = flag_q[0];
   assign abw_flag = flag_q[1];
   assign bwm_irq  = flag_irq[0];
   assign abw_irq  = flag_irq[1];

   // Control outputs toward the training machine.
   assign link_ctl_o.link_disable  = link_dis;
   assign link_ctl_o.retrain_pulse = retrain_req;
   assign link_ctl_o.l0s_enable    = aspm_ctl[0];
   assign link_ctl_o.l1_enable     = aspm_ctl[1];
   assign link_ctl_o.rx_l0s_allow  = 1'b1;
   assign link_ctl_o.common_clk    = common_clk;
   assign link_ctl_o.ext_sync      = ext_sync;
   assign link_ctl_o.surprise_en   = is_down & surprise_en;
   assign link_ctl_o.bwm_irq_req   = bwm_irq;
   assign link_ctl_o.abw_irq_req   = abw_irq;

   assign fts_count_o    = ext_sync ? 13'(PLCSC_EXT_FTS_COUNT) : 13'h0000;
   assign ts1_count_o    = ext_sync ? 11'(PLCSC_EXT_TS1_COUNT)
                                    : 11'(PLCSC_STD_TS1_COUNT);
   assign port_present_o = present;
endmodule

//--- tb/plcsc_chk.sv
/*
 Port assertions for the link register pair.
 Assumes one clock domain and is bound into plcsc_regs.
*/
`timescale 1ns/1ps
module plcsc_chk
(
   // Clock and reset
   input wire logic                       sys_clk_i,
   input wire logic                       rst_b_i,
   // Watched ports
   input wire logic [1:0]                 port_index_i,
   input wire logic                       reg_wr_i,
   input wire logic                       reg_rd_i,
   input wire logic [11:0]                reg_addr_i,
   input wire logic [31:0]                reg_wdata_i,
   input wire logic [31:0]                reg_rdata_o,
   input wire plcsc_pkg::plcsc_link_sts_t link_sts_i,
   input wire plcsc_pkg::plcsc_link_ctl_t link_ctl_o,
   input wire logic [12:0]                fts_count_o,
   input wire logic [10:0]                ts1_count_o
);
   import plcsc_pkg::*;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Strobe-cycle copies, so each consequent sees the cause one edge later.
   logic        fast_q;
   logic [31:0] wd_q;
   always_ff @(posedge sys_clk_i)
   begin
      fast_q <= link_sts_i.link_up && link_sts_i.speed_5g;
      wd_q   <= reg_wdata_i;
   end
   sequence s_cap_rd; reg_rd_i && reg_addr_i == PLCSC_OFS_LINK_CAP; endsequence
   sequence s_ctl_rd; reg_rd_i && reg_addr_i == PLCSC_OFS_LINK_STSCTL; endsequence
   sequence s_ctl_wr; reg_wr_i && reg_addr_i == PLCSC_OFS_LINK_STSCTL; endsequence
   property p_codes;
      s_cap_rd |=> reg_rdata_o[3:0] == 4'h2 && reg_rdata_o[11:10] == 2'h3;
   endproperty
   a_codes: assert property (p_codes) else $error("capability codes wrong");
   property p_lat;
      s_cap_rd |=> reg_rdata_o[17:12] == (fast_q ? 6'h0c : 6'h15);
   endproperty
   a_lat: assert property (p_lat) else $error("exit latency wrong");
   property p_retrain;
      s_ctl_wr ##0 (reg_wdata_i[5] && port_index_i != 2'h0) |-> link_ctl_o.retrain_pulse;
   endproperty
   a_retrain: assert property (p_retrain) else $error("no retrain pulse");
   property p_rz;
      s_ctl_rd |=> !reg_rdata_o[5];
   endproperty
   a_rz: assert property (p_rz) else $error("retrain bit read one");
   property p_aspm;
      s_ctl_wr |=> {link_ctl_o.l1_enable, link_ctl_o.l0s_enable} == wd_q[1:0];
   endproperty
   a_aspm: assert property (p_aspm) else $error("power state enables wrong");
   property p_dis;
      s_ctl_wr |=> link_ctl_o.link_disable == (wd_q[4] && port_index_i != 2'h0);
   endproperty
   a_dis: assert property (p_dis) else $error("link disable wrong");
   property p_cclk;
      s_ctl_wr |=> link_ctl_o.common_clk == wd_q[6] && link_ctl_o.ext_sync == wd_q[7];
   endproperty
   a_cclk: assert property (p_cclk) else $error("clock or sync control wrong");
   property p_ext;
      fts_count_o == (link_ctl_o.ext_sync ? 13'h1000 : 13'h0000)
         && ts1_count_o == (link_ctl_o.ext_sync ? 11'h400 : 11'h010);
   endproperty
   a_ext: assert property (p_ext) else $error("ordered set count wrong");
   property p_rx;
      link_ctl_o.rx_l0s_allow;
   endproperty
   a_rx: assert property (p_rx) else $error("receiver idle entry blocked");
   property p_up;
      port_index_i == 2'h0 |-> !(link_ctl_o.bwm_irq_req || link_ctl_o.abw_irq_req);
   endproperty
   a_up: assert property (p_up) else $error("upstream interrupt request");
   property p_unmap;
      reg_rd_i && reg_addr_i != PLCSC_OFS_LINK_CAP && reg_addr_i != PLCSC_OFS_LINK_STSCTL
         |=> reg_rdata_o == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule

bind plcsc_regs plcsc_chk i_chk (.sys_clk_i, .rst_b_i, .port_index_i, .reg_wr_i,
   .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .link_sts_i, .link_ctl_o,
   .fts_count_o, .ts1_count_o);

//--- tb/plcsc_link_model.sv
/*
 Far-side training machine model for one port.
 Assumes the bench supplies the static link state in base_i.
*/
`timescale 1ns/1ps
module plcsc_link_model
(
   // Clock and reset
   input  wire logic                       sys_clk_i,
   input  wire logic                       rst_b_i,
   // Link state and controls
   input  wire plcsc_pkg::plcsc_link_sts_t base_i,
   input  wire plcsc_pkg::plcsc_link_ctl_t ctl_i,
   output plcsc_pkg::plcsc_link_sts_t      sts_o
);
   import plcsc_pkg::*;
   logic [2:0] wait_q;
   // Retraining takes a few cycles, so the training bit is seen pending.
   always_ff @(posedge sys_clk_i)
   begin
      if (!rst_b_i)
         wait_q <= 3'h0;
      else if (ctl_i.retrain_pulse)
         wait_q <= 3'h4;
      else if (wait_q != 3'h0)
         wait_q <= wait_q - 3'h1;
   end
   always_comb
   begin
      sts_o = base_i;
      sts_o.training = (wait_q != 3'h0);
      sts_o.retrain_done = (wait_q == 3'h1);
      if (ctl_i.link_disable)
      begin
         sts_o.link_up = 1'b0;
         sts_o.dll_active = 1'b0;
      end
   end
endmodule

//--- tb/testbench.sv
/*
 Self-checking bench for the link register pair.
 Assumes the far-side model stands in for the training machine.
*/
`timescale 1ns/1ps
module testbench;
   import plcsc_pkg::*;
   logic            sys_clk = 1'b0;
   logic            rst_b = 1'b0;
   logic [1:0]      port = 2'h0;
   logic            strap = 1'b0;
   logic            wr = 1'b0;
   logic            rd = 1'b0;
   logic [11:0]     addr = 12'h0;
   logic [31:0]     wdata = 32'h0;
   logic [31:0]     rdata;
   logic            rvalid;
   logic [12:0]     fts;
   logic [10:0]     ts1;
   logic            present;
   logic            ovr_v = 1'b0;
   logic            ovr = 1'b0;
   logic            sov_we = 1'b0;
   logic            sov = 1'b0;
   plcsc_link_sts_t base = '0;
   plcsc_link_sts_t sts;
   plcsc_link_ctl_t ctl;
   logic [31:0]     d;
   int              bad_count = 0;
   int              compares = 0;
   plcsc_regs i_dut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .port_index_i(port),
      .port_layout_strap_input_i(strap), .strap_override_valid_i(ovr_v),
      .strap_override_i(ovr), .surprise_override_we_i(sov_we), .surprise_override_i(sov),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .link_sts_i(sts), .link_ctl_o(ctl),
      .fts_count_o(fts), .ts1_count_o(ts1), .port_present_o(present));
   plcsc_link_model i_far (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .base_i(base),
      .ctl_i(ctl), .sts_o(sts));
   initial
   begin
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic start(input logic [1:0] p, input logic s);
      @(negedge sys_clk);
      rst_b = 1'b0;
      port = p;
      strap = s;
      base = '0;
      repeat (10) @(negedge sys_clk);
      rst_b = 1'b1;
   endtask
   task automatic rd_reg(input logic [11:0] a);
      @(negedge sys_clk);
      rd = 1'b1;
      addr = a;
      @(negedge sys_clk);
      rd = 1'b0;
      d = rdata;
      check({31'h0, rvalid}, 32'h1);
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
      @(negedge sys_clk);
      wr = 1'b1;
      addr = a;
      wdata = v;
      @(negedge sys_clk);
      wr = 1'b0;
   endtask
   function automatic logic [31:0] cap(input logic [1:0] p, input logic f,
      input logic [5:0] w);
      logic dn;
      dn = (p != 2'h0);
      return {6'h0, p, 2'h0, dn, dn, dn, 1'b0, f ? 6'h0c : 6'h15, 2'h3, w, 4'h2};
   endfunction
   task automatic t_reset();
      for (int i = 0; i < 4; i += 2)
      begin
         start(2'(i), 1'b0);
         rd_reg(12'h074);
         check(d, cap(2'(i), 1'b0, 6'h01));
         check({31'h0, present}, 32'h1);
         check({31'h0, ctl.surprise_en}, {31'h0, i != 0});
         rd_reg(12'h078);
         check(d, 32'h0011_0000);
         rd_reg(12'h07c);
         check(d, 32'h0);
      end
   endtask
   task automatic t_speed();
      start(2'h1, 1'b0);
      base.link_up = 1'b1;
      base.speed_5g = 1'b1;
      base.dll_active = 1'b1;
      base.fc_init_done = 1'b1;
      rd_reg(12'h074);
      check(d, cap(2'h1, 1'b1, 6'h01));
      rd_reg(12'h078);
      check(d, 32'h2012_0000);
      base.fc_init_done = 1'b0;
      rd_reg(12'h078);
      check(d, 32'h0012_0000);
   endtask
   task automatic t_strap();
      start(2'h0, 1'b1);
      base.link_up = 1'b1;
      base.dll_active = 1'b1;
      base.width = 6'h02;
      rd_reg(12'h074);
      check(d, cap(2'h0, 1'b0, 6'h02));
      rd_reg(12'h078);
      check(d, 32'h0021_0000);
      start(2'h1, 1'b1);
      @(negedge sys_clk);
      check({31'h0, present}, 32'h0);
   endtask
   task automatic t_ctl();
      for (int i = 0; i < 4; i += 3)
      begin
         start(2'(i), 1'b0);
         wr_reg(12'h078, 32'hffff_ffff);
         check({31'h0, ctl.link_disable}, i != 0);
         check({8'h0, fts, ts1}, {8'h0, 13'h1000, 11'h400});
         rd_reg(12'h078);
         check(d, i != 0 ? 32'h0811_0cd3 : 32'h0011_00c3);
         wr_reg(12'h078, 32'h0);
         check({8'h0, fts, ts1}, {8'h0, 13'h0000, 11'h010});
      end
   endtask
   task automatic t_flags();
      start(2'h2, 1'b0);
      wr_reg(12'h078, 32'h0000_0420);
      repeat (8) @(negedge sys_clk);
      rd_reg(12'h078);
      check(d, 32'h4011_0400);
      check({31'h0, ctl.bwm_irq_req}, 32'h1);
      wr_reg(12'h078, 32'h4000_0400);
      rd_reg(12'h078);
      check(d, 32'h0011_0400);
      @(negedge sys_clk);
      base.reliab_change = 1'b1;
      base.went_down = 1'b1;
      @(negedge sys_clk);
      base = '0;
      rd_reg(12'h078);
      check(d, 32'h0011_0400);
      base.auto_change = 1'b1;
      @(negedge sys_clk);
      base.auto_change = 1'b0;
      rd_reg(12'h078);
      check(d, 32'h8011_0400);
      check({31'h0, ctl.abw_irq_req}, 32'h0);
      base.reliab_change = 1'b1;
      @(negedge sys_clk);
      base.reliab_change = 1'b0;
      rd_reg(12'h078);
      check(d, 32'hc011_0400);
      base.auto_change = 1'b1;
      wr_reg(12'h078, 32'hc000_0400);
      base.auto_change = 1'b0;
      rd_reg(12'h078);
      check(d, 32'h8011_0400);
   endtask
   task automatic t_ovr();
      start(2'h0, 1'b0);
      ovr_v = 1'b1;
      ovr = 1'b1;
      @(negedge sys_clk);
      ovr_v = 1'b0;
      rd_reg(12'h074);
      check(d, cap(2'h0, 1'b0, 6'h02));
      start(2'h3, 1'b0);
      base.link_up = 1'b1;
      sov_we = 1'b1;
      @(negedge sys_clk);
      sov_we = 1'b0;
      rd_reg(12'h074);
      check(d, cap(2'h3, 1'b0, 6'h01) & ~32'h0008_0000);
      check({31'h0, ctl.surprise_en}, 32'h0);
   endtask
   task automatic conclude();
      if (bad_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #1_000_000;
      bad_count++;
      conclude();
   end
   initial
   begin
      t_reset();
      t_speed();
      t_strap();
      t_ctl();
      t_flags();
      t_ovr();
      conclude();
   end
endmodule
